// File: src/spr_core.sv
// scanner processor storage: local store, permanent code store, control store, registers
// assumes microcode requests come from same-clock logic; event pins are synchronised
// What this block does
// - local store of 128 bytes, byte or halfword addressed
// - local store is 16 pages of eight one-byte registers
// - local store page register sits at external address 1F
// - permanent code store of 4K halfwords, halfword addressed
// - permanent code store is read only, writes ignored
// - control store of 64K halfwords, halfword addressed
// - control store carries error correcting code per module
// - uncorrectable control store error sets error register 03 bit 1
// - uncorrectable error raises hardstop and sends two parity status bytes
// - 32 external registers, eight bits each
// - register reads on odd data-in, writes from odd data-out
// - register bits settable and clearable by hardware and microcode
// - compare address in 1C/1D raises interrupt when reached
// - scanner cycle steal to control store handled fully in hardware
// - scanner and processor clocks derived from one basic clock
// - couplers with all lines inactive are not scanned
// - error register at 03, external interrupt request at 05
// - hardstop blocks all control store access, halting microcode and scanner cycle steal
`timescale 1ns/1ns
`default_nettype none
`include "spr_regs.svh"
module spr_core import spr_pkg::*; #(
  parameter int CS_WORDS = `SPR_CS_HALFWORDS,
  parameter int CS_AW = 16,
  parameter int NUM_COUPLERS = 16,
  parameter logic [15:0] PCS_FILL = 16'h0000
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire spr_ext_req_t ext_req_i,
  output logic [7:0] ext_odd_din_o,
  input wire spr_ls_req_t ls_req_i,
  output logic [15:0] ls_rdata_o,
  input wire logic pcs_rd_i,
  input wire logic [11:0] pcs_addr_i,
  output logic [15:0] pcs_rdata_o,
  input wire spr_cs_req_t cs_req_i,
  output logic cs_grant_o,
  output logic [15:0] cs_rdata_o,
  input wire spr_cs_req_t fes_req_i,
  output logic fes_ack_o,
  output logic [15:0] fes_rdata_o,
  input wire logic [NUM_COUPLERS-1:0] coupler_active_i,
  output logic [NUM_COUPLERS-1:0] coupler_scan_o,
  input wire logic [7:0] hw_set_i [`SPR_EXT_REGS],
  input wire logic [7:0] hw_clr_i [`SPR_EXT_REGS],
  input wire logic hardstop_reset_i,
  output logic cmp_irq_o,
  output logic hardstop_o,
  output spr_status_byte_t status_o,
  output logic basic_clk_en_o
);
  localparam logic [31:0] ACC_STEP = 32'(longint'(`SPR_BASIC_CLK_HZ) * 64'h100000000 /
    `SPR_SYS_CLK_HZ);
  logic [7:0] ext_reg [`SPR_EXT_REGS];
  logic [7:0] ls_reg [`SPR_LS_BYTES];
  logic [21:0] cs_mem [CS_WORDS];
  logic [15:0] pcs_rom [`SPR_PCS_HALFWORDS];
  logic [7:0] cs_uncorr_cnt;
  logic [31:0] acc_reg;
  logic [NUM_COUPLERS-1:0] act_s1_reg, act_s2_reg;
  spr_state_t state_reg;
  logic [0:0] st_idx_reg;
  logic [15:0] err_status;
  logic [15:0] cs_addr, cs_wdata;
  logic cs_rd, cs_wr, fes_take, mc_take;
  logic [21:0] enc_code, rd_code;
  logic [15:0] dec_data;
  logic dec_corr, dec_uncorr, uncorr_evt, cmp_hit;
  // fixed contents, no write path exists
  always_comb begin
    for (int i = 0; i < `SPR_PCS_HALFWORDS; i++) begin
      pcs_rom[i] = PCS_FILL ^ 16'(i);
    end
  end
  // halfword addressed read of the code store
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pcs_rdata_o <= 16'h0000;
    end else if (pcs_rd_i) begin
      pcs_rdata_o <= pcs_rom[pcs_addr_i];
    end
  end
  // basic clock enable by phase accumulator from the system clock
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      acc_reg <= 32'h00000000;
      basic_clk_en_o <= 1'b0;
    end else begin
      {basic_clk_en_o, acc_reg} <= {1'b0, acc_reg} + {1'b0, ACC_STEP};
    end
  end
  // only couplers with an active line get scan slots
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      act_s1_reg <= '0;
      act_s2_reg <= '0;
      coupler_scan_o <= '0;
    end else begin
      act_s1_reg <= coupler_active_i;
      act_s2_reg <= act_s1_reg;
      coupler_scan_o <= act_s2_reg;
    end
  end
  // page register selects which eight bytes the byte path sees
  logic [6:0] ls_baddr;
  assign ls_baddr = ls_req_i.hw ? ls_req_i.addr :
    {ext_reg[`SPR_LOCAL_STORE_PAGE][3:0], ls_req_i.addr[2:0]};
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < `SPR_LS_BYTES; i++) ls_reg[i] <= 8'h00;
      ls_rdata_o <= 16'h0000;
    end else begin
      if (ls_req_i.wr && ls_req_i.hw) begin
        ls_reg[{ls_baddr[6:1], 1'b0}] <= ls_req_i.wdata[15:8];
        ls_reg[{ls_baddr[6:1], 1'b1}] <= ls_req_i.wdata[7:0];
      end else if (ls_req_i.wr) begin
        ls_reg[ls_baddr] <= ls_req_i.wdata[7:0];
      end
      if (ls_req_i.rd && ls_req_i.hw) begin
        ls_rdata_o <= {ls_reg[{ls_baddr[6:1], 1'b0}], ls_reg[{ls_baddr[6:1], 1'b1}]};
      end else if (ls_req_i.rd) begin
        ls_rdata_o <= {8'h00, ls_reg[ls_baddr]};
      end
    end
  end
  // scanner cycle steal wins; outside run state neither scanner nor microcode gets the store
  assign fes_take = (fes_req_i.rd || fes_req_i.wr) && state_reg == SPR_ST_RUN;
  assign mc_take = (cs_req_i.rd || cs_req_i.wr) && !fes_take && state_reg == SPR_ST_RUN;
  assign cs_addr = fes_take ? fes_req_i.addr : cs_req_i.addr;
  assign cs_wdata = fes_take ? fes_req_i.wdata : cs_req_i.wdata;
  assign cs_rd = fes_take ? fes_req_i.rd : (mc_take && cs_req_i.rd);
  assign cs_wr = fes_take ? fes_req_i.wr : (mc_take && cs_req_i.wr);
  assign rd_code = cs_mem[cs_addr[CS_AW-1:0]];
  // encode on write, correct on read
  spr_ecc u_ecc (
    .data_i(cs_wdata),
    .code_i(rd_code),
    .code_o(enc_code),
    .data_o(dec_data),
    .corr_o(dec_corr),
    .uncorr_o(dec_uncorr)
  );
  assign uncorr_evt = cs_rd && dec_uncorr;
  always_ff @(posedge clk_i) begin
    if (cs_wr) cs_mem[cs_addr[CS_AW-1:0]] <= enc_code;
  end
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cs_grant_o <= 1'b0;
      fes_ack_o <= 1'b0;
      cs_rdata_o <= 16'h0000;
      fes_rdata_o <= 16'h0000;
      cs_uncorr_cnt <= 8'h00;
    end else begin
      cs_grant_o <= mc_take;
      fes_ack_o <= fes_take;
      if (mc_take && cs_req_i.rd) cs_rdata_o <= dec_data;
      if (fes_take && fes_req_i.rd) fes_rdata_o <= dec_data;
      if (uncorr_evt && cs_uncorr_cnt != 8'hFF) cs_uncorr_cnt <= cs_uncorr_cnt + 8'h01;
    end
  end
  // compare address against the enabled compare bytes
  assign cmp_hit = cs_rd && mc_take &&
    ext_reg[`SPR_ADDR_COMPARE_CONTROL][`SPR_CMP_ENABLE_BIT] &&
    cs_addr == {ext_reg[`SPR_ADDR_COMPARE_BYTE0], ext_reg[`SPR_ADDR_COMPARE_BYTE1]};
  // register bank, hardware set wins over clears
  generate
    for (genvar g = 0; g < `SPR_EXT_REGS; g++) begin : g_ext
      localparam logic [4:0] A = 5'(g);
      localparam bit USED = !(A == `SPR_UNUSED_06 || A == `SPR_UNUSED_08 ||
        A == `SPR_UNUSED_09 || A == `SPR_UNUSED_11 || A == `SPR_UNUSED_18 ||
        A == 5'h0D || A == 5'h0E || A == 5'h0F);
      logic [7:0] evt_set;
      always_comb begin
        evt_set = hw_set_i[g];
        // uncorrectable error sets bit 1 of the error register
        if (A == `SPR_PROCESSOR_ERROR && uncorr_evt) evt_set[`SPR_ERR_UNCORR_BIT] = 1'b1;
        if (A == `SPR_CURRENT_IRQ_LEVEL && (cmp_hit || uncorr_evt) &&
            !ext_reg[`SPR_IRQ_MASKS][`SPR_LVL_ERROR]) evt_set[`SPR_LVL_ERROR] = 1'b1;
      end
      always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          ext_reg[g] <= 8'h00;
        end else if (USED) begin
          if (ext_req_i.wr && ext_req_i.addr == A) begin
            ext_reg[g] <= ext_req_i.wdata | evt_set;
          end else begin
            ext_reg[g] <= (ext_reg[g] & ~hw_clr_i[g]) | evt_set;
          end
        end
      end
    end
  endgenerate
  // read data on the odd data-in path
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ext_odd_din_o <= 8'h00;
    end else if (ext_req_i.rd) begin
      ext_odd_din_o <= ext_reg[ext_req_i.addr];
    end
  end
  // interrupt pulse unless level 0 is masked
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cmp_irq_o <= 1'b0;
    end else begin
      cmp_irq_o <= cmp_hit && !ext_reg[`SPR_IRQ_MASKS][`SPR_LVL_ERROR];
    end
  end
  // hardstop sends two status bytes with odd parity, then halts
  assign err_status = {ext_reg[`SPR_PROCESSOR_ERROR], cs_uncorr_cnt};
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg <= SPR_ST_RUN;
      st_idx_reg <= 1'b0;
      hardstop_o <= 1'b0;
      status_o <= '0;
    end else begin
      status_o.valid <= 1'b0;
      unique case (state_reg)
        SPR_ST_RUN: begin
          if (uncorr_evt) begin
            state_reg <= SPR_ST_SEND;
            hardstop_o <= 1'b1;
            st_idx_reg <= 1'b0;
          end
        end
        SPR_ST_SEND: begin
          status_o.valid <= 1'b1;
          status_o.data <= st_idx_reg ? err_status[7:0] : err_status[15:8];
          status_o.parity <= ~^(st_idx_reg ? err_status[7:0] : err_status[15:8]);
          st_idx_reg <= ~st_idx_reg;
          if (st_idx_reg) state_reg <= SPR_ST_HALT;
        end
        SPR_ST_HALT: begin
          if (hardstop_reset_i) begin
            state_reg <= SPR_ST_RUN;
            hardstop_o <= 1'b0;
          end
        end
        default: state_reg <= SPR_ST_RUN;
      endcase
    end
  end
  a_halt_no_grant: assert property (@(posedge clk_i) disable iff (!resetn_i)
    hardstop_o |=> !cs_grant_o && !fes_ack_o) else $error("grant during hardstop");
  a_uncorr_err_bit: assert property (@(posedge clk_i) disable iff (!resetn_i)
    uncorr_evt |=> ext_reg[`SPR_PROCESSOR_ERROR][`SPR_ERR_UNCORR_BIT])
    else $error("error bit not set");
  a_hardstop_two_bytes: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (state_reg == SPR_ST_RUN && uncorr_evt) |=> ##1 status_o.valid ##1 status_o.valid
    ##1 !status_o.valid) else $error("status bytes wrong");
  a_status_parity: assert property (@(posedge clk_i) disable iff (!resetn_i)
    status_o.valid |-> ^{status_o.data, status_o.parity}) else $error("bad parity");
  a_steal_priority: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (fes_take && (cs_req_i.rd || cs_req_i.wr)) |=> !cs_grant_o && fes_ack_o)
    else $error("microcode beat cycle steal");
  a_cmp_irq_hit: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (cmp_hit && !ext_reg[`SPR_IRQ_MASKS][0]) |=> cmp_irq_o) else $error("compare missed");
  a_unused_zero: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (ext_req_i.rd && ext_req_i.addr == `SPR_UNUSED_06) |=> ext_odd_din_o == 8'h00)
    else $error("unused reads nonzero");
  a_scan_inactive: assert property (@(posedge clk_i) disable iff (!resetn_i)
    coupler_scan_o == $past(coupler_active_i, 3)) else $error("inactive coupler scanned");
  a_hw_set_wins: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (hw_set_i[`SPR_IRQ_MASKS][0] && hw_clr_i[`SPR_IRQ_MASKS][0]) |=>
    ext_reg[`SPR_IRQ_MASKS][0]) else $error("set lost to clear");
endmodule : spr_core
`default_nettype wire

// File: src/spr_regs.svh
// constants for the scanner processor storage and external register bank
// assumes a single 100 MHz clock; the basic clock rate is divided from it
`ifndef SPR_REGS_SVH
`define SPR_REGS_SVH
`define SPR_MISC_CONTROL 5'h00
`define SPR_IO_BUS_CONTROL 5'h01
`define SPR_IO_BUS_SERVICE 5'h02
`define SPR_PROCESSOR_ERROR 5'h03
`define SPR_PROCESSOR_MISC 5'h04
`define SPR_EXTERNAL_IRQ_REQUEST 5'h05
`define SPR_UNUSED_06 5'h06
`define SPR_SYNC_CONFIG_DATA_SET 5'h07
`define SPR_UNUSED_08 5'h08
`define SPR_UNUSED_09 5'h09
`define SPR_FAST_LINE_ID_BYTE0 5'h0A
`define SPR_FAST_LINE_ID_BYTE1 5'h0B
`define SPR_ALTERNATE_SCANNER_ADDRESS 5'h0C
`define SPR_EXTENDED_IRQ_REQUEST 5'h10
`define SPR_UNUSED_11 5'h11
`define SPR_IRQ_LINE_INTERFACE_ADDR 5'h12
`define SPR_ASYNC_RAM_ACCESS_A 5'h13
`define SPR_DATA_IN_OUT 5'h14
`define SPR_ASYNC_RAM_ACCESS_B 5'h15
`define SPR_ASYNC_OPERATION_STATUS 5'h16
`define SPR_FRONT_END_GENERAL_COMMAND 5'h17
`define SPR_UNUSED_18 5'h18
`define SPR_IO_IRQ_LEVEL_REQUEST 5'h19
`define SPR_CURRENT_IRQ_LEVEL 5'h1A
`define SPR_ADDR_COMPARE_CONTROL 5'h1B
`define SPR_ADDR_COMPARE_BYTE0 5'h1C
`define SPR_ADDR_COMPARE_BYTE1 5'h1D
`define SPR_IRQ_MASKS 5'h1E
`define SPR_LOCAL_STORE_PAGE 5'h1F
// field positions
`define SPR_ERR_UNCORR_BIT 1
`define SPR_CMP_ENABLE_BIT 0
`define SPR_LVL_ERROR 0
// sizes
`define SPR_LS_BYTES 128
`define SPR_LS_PAGES 16
`define SPR_LS_PAGE_REGS 8
`define SPR_PCS_HALFWORDS 4096
`define SPR_CS_HALFWORDS 65536
`define SPR_EXT_REGS 32
// timing: basic clock in Hz, system clock in Hz
`define SPR_BASIC_CLK_HZ 29491200
`define SPR_SYS_CLK_HZ 100000000
`define SPR_STATUS_BYTES 2
`endif

// File: src/spr_pkg.sv
// types for the scanner processor storage and register bank
// assumes the constants header is included by users
package spr_pkg;
  typedef struct packed {
    logic rd;
    logic wr;
    logic [4:0] addr;
    logic [7:0] wdata;
  } spr_ext_req_t;
  typedef struct packed {
    logic rd;
    logic wr;
    logic hw;
    logic [6:0] addr;
    logic [15:0] wdata;
  } spr_ls_req_t;
  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [15:0] wdata;
  } spr_cs_req_t;
  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic parity;
  } spr_status_byte_t;
  typedef enum logic [2:0] {
    SPR_ST_RUN = 3'b001,
    SPR_ST_SEND = 3'b010,
    SPR_ST_HALT = 3'b100
  } spr_state_t;
endpackage : spr_pkg

// File: src/spr_ecc.sv
// single-error-correct, double-error-detect code over one halfword
// assumes a 22-bit stored word: 16 data, 5 hamming, 1 overall parity
`timescale 1ns/1ns
`default_nettype none
module spr_ecc (
  input wire logic [15:0] data_i,
  input wire logic [21:0] code_i,
  output logic [21:0] code_o,
  output logic [15:0] data_o,
  output logic corr_o,
  output logic uncorr_o
);
  function automatic logic [21:0] enc(input logic [15:0] d);
    logic [21:0] c;
    logic [4:0] s;
    integer i;
    integer k;
    c = '0;
    k = 0;
    for (i = 1; i < 22; i++) begin
      if ((i & (i - 1)) != 0) begin
        c[i] = d[k];
        k = k + 1;
      end
    end
    s = '0;
    for (i = 1; i < 22; i++) begin
      if (c[i]) s = s ^ i[4:0];
    end
    for (i = 0; i < 5; i++) begin
      c[1 << i] = s[i];
    end
    c[0] = ^c[21:1];
    return c;
  endfunction : enc
  logic [4:0] syn;
  logic [21:0] fixed;
  always_comb begin
    code_o = enc(data_i);
    syn = '0;
    for (int i = 1; i < 22; i++) begin
      if (code_i[i]) syn = syn ^ i[4:0];
    end
    fixed = code_i;
    corr_o = 1'b0;
    uncorr_o = 1'b0;
    if (syn != 5'h00 && (^code_i)) begin
      corr_o = 1'b1;
      if (syn < 5'd22) fixed[syn] = ~fixed[syn];
      else uncorr_o = 1'b1;
    end else if (syn != 5'h00) begin
      uncorr_o = 1'b1;
    end else if (^code_i) begin
      corr_o = 1'b1;
    end
    data_o = '0;
    for (int i = 1, k = 0; i < 22; i++) begin
      if ((i & (i - 1)) != 0) begin
        data_o[k] = fixed[i];
        k = k + 1;
      end
    end
  end
endmodule : spr_ecc
`default_nettype wire

// File: verification/spr_ccu_model.sv
// far-side control unit model: collects hardstop status bytes, then resets the hardstop
// assumes status bytes arrive one per cycle, marked by their valid bit
`timescale 1ns/1ns
`default_nettype none
module spr_ccu_model
  import spr_pkg::*;
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic hardstop_i,
  input wire spr_status_byte_t status_i,
  output logic [1:0] n_bytes_o,
  output logic bad_parity_o,
  output logic hs_reset_o
);
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      n_bytes_o <= 2'h0;
      bad_parity_o <= 1'b0;
    end else if (!hardstop_i) begin
      // fresh count per hardstop, so a later one is not released early
      n_bytes_o <= 2'h0;
    end else if (status_i.valid) begin
      n_bytes_o <= n_bytes_o + 2'h1;
      if (^{status_i.data, status_i.parity} != 1'b1) begin
        bad_parity_o <= 1'b1;
      end
    end
  end
  // reset only after both bytes, so none is lost
  assign hs_reset_o = hardstop_i && (n_bytes_o == 2'h2);
endmodule : spr_ccu_model
`default_nettype wire

// File: verification/test_scanner_processor_storage_regs.sv
// self-checking bench for the storage and external register bank
// assumes the design core and the control unit model; one 100 MHz clock
`timescale 1ns/1ns
`default_nettype none
`include "spr_regs.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
  $display("Error at %0t: got %0h expected %0h", $time, (g), (e)); end end
module test_scanner_processor_storage_regs
  import spr_pkg::*;
();
  localparam logic [15:0] FILL = 16'h5A3C;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  spr_ext_req_t ext_req;
  spr_ls_req_t ls_req;
  spr_cs_req_t cs_req, fes_req;
  logic pcs_rd;
  logic [11:0] pcs_addr;
  logic [15:0] coupler_active, coupler_scan, ls_rdata, pcs_rdata, cs_rdata, fes_rdata;
  logic [7:0] hw_set [`SPR_EXT_REGS];
  logic [7:0] hw_clr [`SPR_EXT_REGS];
  logic [7:0] ext_din;
  logic cs_grant, fes_ack, cmp_irq, hardstop, basic_en, hs_reset, bad_par;
  logic [1:0] n_bytes;
  spr_status_byte_t status;
  int n_mismatch = 0;
  int n_compared = 0;

  always #5 clk_i = ~clk_i;

  spr_core #(.PCS_FILL(FILL)) u_dut (.clk_i(clk_i), .resetn_i(resetn_i),
    .ext_req_i(ext_req), .ext_odd_din_o(ext_din), .ls_req_i(ls_req), .ls_rdata_o(ls_rdata),
    .pcs_rd_i(pcs_rd), .pcs_addr_i(pcs_addr), .pcs_rdata_o(pcs_rdata), .cs_req_i(cs_req),
    .cs_grant_o(cs_grant), .cs_rdata_o(cs_rdata), .fes_req_i(fes_req), .fes_ack_o(fes_ack),
    .fes_rdata_o(fes_rdata), .coupler_active_i(coupler_active), .coupler_scan_o(coupler_scan),
    .hw_set_i(hw_set), .hw_clr_i(hw_clr), .hardstop_reset_i(hs_reset), .cmp_irq_o(cmp_irq),
    .hardstop_o(hardstop), .status_o(status), .basic_clk_en_o(basic_en));

  spr_ccu_model u_ccu (.clk_i(clk_i), .resetn_i(resetn_i), .hardstop_i(hardstop),
    .status_i(status), .n_bytes_o(n_bytes), .bad_parity_o(bad_par), .hs_reset_o(hs_reset));

  function automatic logic [7:0] exp_rd(input logic [4:0] a, input logic [7:0] v);
    case (a)
      5'h06, 5'h08, 5'h09, 5'h0D, 5'h0E, 5'h0F, 5'h11, 5'h18: exp_rd = 8'h00;
      default: exp_rd = v;
    endcase
  endfunction : exp_rd

  task automatic ext_wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk_i);
    ext_req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge clk_i);
    ext_req <= '0;
  endtask : ext_wr

  task automatic ext_rd(input logic [4:0] a, output logic [7:0] d);
    @(posedge clk_i);
    ext_req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(posedge clk_i);
    ext_req <= '0;
    #1 d = ext_din;
  endtask : ext_rd

  task automatic ls_op(input logic hw, input logic wr, input logic [6:0] a,
      input logic [15:0] wd, output logic [15:0] rd);
    @(posedge clk_i);
    ls_req <= '{rd: !wr, wr: wr, hw: hw, addr: a, wdata: wd};
    @(posedge clk_i);
    ls_req <= '0;
    #1 rd = ls_rdata;
  endtask : ls_op

  // microcode is never refused here, so the answer is due one cycle on
  task automatic cs_op(input logic fes, input logic wr, input logic [15:0] a,
      input logic [15:0] wd, output logic [15:0] rd, output logic irq);
    spr_cs_req_t r;
    r = '{rd: !wr, wr: wr, addr: a, wdata: wd};
    @(posedge clk_i);
    if (fes) fes_req <= r;
    else cs_req <= r;
    @(posedge clk_i);
    fes_req <= '0;
    cs_req <= '0;
    #1 `CHK(fes ? fes_ack : cs_grant, 1'b1)
    rd = fes ? fes_rdata : cs_rdata;
    irq = cmp_irq;
  endtask : cs_op

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask : done

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : summarize

  initial begin
    repeat (40000) @(posedge clk_i);
    n_mismatch++;
    $display("Error at %0t: watchdog expired", $time);
    summarize();
  end

  initial begin
    int a, p, cnt;
    logic [7:0] v, v2, d;
    logic [15:0] w, r, ca;
    logic irq;
    ext_req = '0;
    ls_req = '0;
    cs_req = '0;
    fes_req = '0;
    pcs_rd = 1'b0;
    pcs_addr = 12'h000;
    coupler_active = 16'h0000;
    foreach (hw_set[i]) begin
      hw_set[i] = 8'h00;
      hw_clr[i] = 8'h00;
    end
    void'($urandom(32'h9075C627));
    repeat (10) @(posedge clk_i);
    resetn_i <= 1'b1;
    for (a = 0; a < 32; a++) begin
      ext_rd(a[4:0], d);
      `CHK(d, 8'h00)
    end
    for (a = 0; a < 32; a++) begin
      v = 8'($urandom);
      ext_wr(a[4:0], v);
      ext_rd(a[4:0], d);
      `CHK(d, exp_rd(a[4:0], v))
      ext_wr(a[4:0], 8'h00);
    end
    done("register map");
    foreach (hw_set[i]) begin
      if (i == `SPR_PROCESSOR_ERROR || i == `SPR_EXTERNAL_IRQ_REQUEST) begin
        @(posedge clk_i);
        hw_set[i] <= 8'h02;
        hw_clr[i] <= 8'h03;
        @(posedge clk_i);
        hw_set[i] <= 8'h00;
        hw_clr[i] <= 8'h00;
        ext_rd(5'(i), d);
        `CHK(d, 8'h02)
        ext_wr(5'(i), 8'hFF);
        @(posedge clk_i);
        hw_clr[i] <= 8'h0F;
        @(posedge clk_i);
        hw_clr[i] <= 8'h00;
        ext_rd(5'(i), d);
        `CHK(d, 8'hF0)
        ext_wr(5'(i), 8'h00);
        ext_rd(5'(i), d);
        `CHK(d, 8'h00)
      end
    end
    done("hardware set and clear");
    foreach (hw_set[i]) if (i == 0) for (p = 0; p < 16; p += 5) begin
      v = 8'($urandom);
      v2 = 8'($urandom);
      w = 16'($urandom);
      ext_wr(`SPR_LOCAL_STORE_PAGE, 8'(p));
      ls_op(1'b0, 1'b1, 7'h06, {8'h00, v}, r);
      ls_op(1'b0, 1'b1, 7'h07, {8'h00, v2}, r);
      ls_op(1'b1, 1'b0, 7'(p * 8 + 6), 16'h0000, r);
      `CHK(r, {v, v2})
      ls_op(1'b1, 1'b1, 7'(p * 8), w, r);
      ls_op(1'b0, 1'b0, 7'h01, 16'h0000, r);
      `CHK(r[7:0], w[7:0])
    end
    done("local store pages");
    for (a = 0; a < 6; a++) begin
      w = (a == 0) ? 16'h0000 : (a == 5) ? 16'h0FFF : 16'($urandom_range(4095));
      @(posedge clk_i);
      pcs_rd <= 1'b1;
      pcs_addr <= w[11:0];
      @(posedge clk_i);
      pcs_rd <= 1'b0;
      #1 `CHK(pcs_rdata, FILL ^ w)
    end
    done("permanent code store");
    for (a = 0; a < 8; a++) begin
      ca = (a == 0) ? 16'h0000 : (a == 7) ? 16'hFFFF : 16'($urandom);
      w = 16'($urandom);
      cs_op(1'b0, 1'b1, ca, w, r, irq);
      cs_op(1'b1, 1'b0, ca, 16'h0000, r, irq);
      `CHK(r, w)
      cs_op(1'b0, 1'b0, ca, 16'h0000, r, irq);
      `CHK(r, w)
    end
    @(posedge clk_i);
    cs_req <= '{rd: 1'b1, wr: 1'b0, addr: ca, wdata: 16'h0000};
    fes_req <= '{rd: 1'b1, wr: 1'b0, addr: ca, wdata: 16'h0000};
    @(posedge clk_i);
    fes_req <= '0;
    #1 `CHK({fes_ack, cs_grant}, 2'b10)
    @(posedge clk_i);
    cs_req <= '0;
    #1 `CHK({cs_grant, cs_rdata}, {1'b1, w})
    done("control store and cycle steal");
    ca = 16'($urandom);
    cs_op(1'b0, 1'b1, ca, 16'h1234, r, irq);
    ext_wr(`SPR_ADDR_COMPARE_BYTE0, ca[15:8]);
    ext_wr(`SPR_ADDR_COMPARE_BYTE1, ca[7:0]);
    ext_wr(`SPR_ADDR_COMPARE_CONTROL, 8'h01);
    cs_op(1'b0, 1'b0, ca, 16'h0000, r, irq);
    `CHK(irq, 1'b1)
    ext_rd(`SPR_CURRENT_IRQ_LEVEL, d);
    `CHK(d[0], 1'b1)
    ext_wr(`SPR_CURRENT_IRQ_LEVEL, 8'h00);
    ext_wr(`SPR_IRQ_MASKS, 8'h01);
    cs_op(1'b0, 1'b0, ca, 16'h0000, r, irq);
    `CHK(irq, 1'b0)
    ext_rd(`SPR_CURRENT_IRQ_LEVEL, d);
    `CHK(d[0], 1'b0)
    done("address compare");
    for (a = 0; a < 4; a++) begin
      @(posedge clk_i);
      coupler_active <= (a == 0) ? 16'h0000 : 16'($urandom);
      repeat (4) @(posedge clk_i);
      #1 `CHK(coupler_scan, coupler_active)
    end
    cnt = 0;
    // averaging over 1000 cycles tolerates the divider's jitter
    repeat (1000) begin
      @(posedge clk_i);
      #1 cnt += int'(basic_en);
    end
    `CHK(cnt >= 293 && cnt <= 296, 1'b1)
    `CHK({hardstop, n_bytes, bad_par}, 4'h0)
    done("scan and clocks");
    summarize();
  end
endmodule : test_scanner_processor_storage_regs
`default_nettype wire
